// ---- verilog/dwsp_defs.vh ----
// constants for the dual wiper serial shift port
`ifndef DWSP_DEFS_VH
`define DWSP_DEFS_VH
`define DWSP_SR_WIDTH 17
`define DWSP_WIPER_WIDTH 8
`define DWSP_STACK_BIT 0
`define DWSP_W1_MSB_POS 1
`define DWSP_W0_MSB_POS 9
`define DWSP_LAST_POS 16
`define DWSP_CASCADE_POS 0
`define DWSP_MIDSCALE 8'h80
`define DWSP_SR_RESET 17'h00202
`endif

// ---- verilog/dwsp_top.v ----
// serial control port of a dual digital potentiometer
// How it works
// - port select low: serial clock and data ignored, no shifting
// - while selected, data shifts in on each serial clock rising edge
// - 17-bit shift register, position 0 holds stack select
// - positions 1..8 hold wiper one value, msb at position 1
// - positions 9..16 hold wiper zero value, msb at position 9
// - falling port select loads latches; wipers change at no other time
// - wiper latches start at midscale after reset
// - stacked output picks wiper zero on 0, wiper one on 1
// - cascade output shows the last shift register stage
// - cascade output always driven regardless of port select
// - loop-back: last bit on cascade output, each edge recirculates it
// - after 17 clocks data returns; deselect reloads same values
`timescale 1ns/1ps
`default_nettype none
`include "dwsp_defs.vh"
module dwsp_top (
  input wire sys_clk,
  input wire sys_rst,
  input wire port_select,
  input wire serial_clk,
  input wire serial_data,
  output wire cascade_out,
  output reg [7:0] wiper_zero_terminal,
  output reg [7:0] wiper_one_terminal,
  output reg stack_select,
  output reg [7:0] stacked_out
);
  // port sequencing, one-hot
  localparam [2:0] PORT_IDLE = 3'h1;
  localparam [2:0] PORT_SHIFT = 3'h2;
  localparam [2:0] PORT_LOAD = 3'h4;

  // three stage samplers; stage 1 feeds only stage 2
  reg [2:0] sel_sync_q;
  reg [2:0] clk_sync_q;
  reg [2:0] dat_sync_q;

  // accepted pin levels, updated only when stages 2 and 3 agree
  reg sel_q;
  reg sel_d;
  reg sclk_q;
  reg sclk_d;
  reg dat_q;
  reg dat_d;

  // port state
  reg [2:0] port_q;
  reg [2:0] port_d;

  // shift register: bit n holds position n
  reg [`DWSP_SR_WIDTH-1:0] shift_q;
  reg [`DWSP_SR_WIDTH-1:0] shift_d;

  // next values of the output registers
  reg [`DWSP_WIPER_WIDTH-1:0] wiper_zero_d;
  reg [`DWSP_WIPER_WIDTH-1:0] wiper_one_d;
  reg stack_select_d;
  reg [`DWSP_WIPER_WIDTH-1:0] stacked_out_d;

  wire sel_agree;
  wire clk_agree;
  wire dat_agree;
  wire sel_rise;
  wire sel_fall;
  wire clk_rise;
  wire shift_en;
  wire load_en;

  // a wiper field keeps its msb at the lower position, so the bits come out reversed
  function [`DWSP_WIPER_WIDTH-1:0] wiper_field;
    input [`DWSP_SR_WIDTH-1:0] sr;
    input integer msb_pos;
    integer i;
    begin
      wiper_field = {`DWSP_WIPER_WIDTH{1'h0}};
      for (i = 0; i < `DWSP_WIPER_WIDTH; i = i + 1) begin
        wiper_field[`DWSP_WIPER_WIDTH-1-i] = sr[msb_pos+i];
      end
    end
  endfunction

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sel_sync_q <= 3'h0;
      clk_sync_q <= 3'h0;
      dat_sync_q <= 3'h0;
    end else begin
      sel_sync_q <= {sel_sync_q[1:0], port_select};
      clk_sync_q <= {clk_sync_q[1:0], serial_clk};
      dat_sync_q <= {dat_sync_q[1:0], serial_data};
    end
  end

  // a change is accepted only once stages 2 and 3 agree
  assign sel_agree = (sel_sync_q[1] == sel_sync_q[2]);
  assign clk_agree = (clk_sync_q[1] == clk_sync_q[2]);
  assign dat_agree = (dat_sync_q[1] == dat_sync_q[2]);

  always @* begin
    sel_d = sel_q;
    sclk_d = sclk_q;
    dat_d = dat_q;
    if (sel_agree) begin
      sel_d = sel_sync_q[2];
    end
    if (clk_agree) begin
      sclk_d = clk_sync_q[2];
    end
    if (dat_agree) begin
      dat_d = dat_sync_q[2];
    end
  end

  // idle levels are low, so reset leaves no false edge behind
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sel_q <= 1'h0;
      sclk_q <= 1'h0;
      dat_q <= 1'h0;
    end else begin
      sel_q <= sel_d;
      sclk_q <= sclk_d;
      dat_q <= dat_d;
    end
  end

  assign sel_rise = sel_agree && sel_sync_q[2] && !sel_q;
  assign sel_fall = sel_agree && !sel_sync_q[2] && sel_q;
  assign clk_rise = clk_agree && clk_sync_q[2] && !sclk_q;

  // the load step lasts one cycle; select cannot pass the voters again that soon
  always @* begin
    port_d = port_q;
    case (port_q)
      PORT_IDLE: begin
        if (sel_rise) begin
          port_d = PORT_SHIFT;
        end
      end
      PORT_SHIFT: begin
        if (sel_fall) begin
          port_d = PORT_LOAD;
        end
      end
      PORT_LOAD: begin
        port_d = PORT_IDLE;
      end
      default: begin
        port_d = PORT_IDLE;
      end
    endcase
  end

  assign shift_en = (port_q == PORT_SHIFT) && clk_rise;
  assign load_en = (port_q == PORT_LOAD);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      port_q <= PORT_IDLE;
    end else begin
      port_q <= port_d;
    end
  end

  // bits enter at position 16 and walk toward position 0, so the first bit sent ends in position 0
  always @* begin
    shift_d = shift_q;
    if (shift_en) begin
      shift_d = {dat_q, shift_q[`DWSP_SR_WIDTH-1:1]};
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_q <= `DWSP_SR_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  // latches move only in the load step, never while bits are arriving
  always @* begin
    wiper_zero_d = wiper_zero_terminal;
    wiper_one_d = wiper_one_terminal;
    stack_select_d = stack_select;
    if (load_en) begin
      stack_select_d = shift_q[`DWSP_STACK_BIT];
      wiper_one_d = wiper_field(shift_q, `DWSP_W1_MSB_POS);
      wiper_zero_d = wiper_field(shift_q, `DWSP_W0_MSB_POS);
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wiper_zero_terminal <= `DWSP_MIDSCALE;
      wiper_one_terminal <= `DWSP_MIDSCALE;
      stack_select <= 1'h0;
    end else begin
      wiper_zero_terminal <= wiper_zero_d;
      wiper_one_terminal <= wiper_one_d;
      stack_select <= stack_select_d;
    end
  end

  // stacked output trails the latches by one cycle, so it too moves only after a load
  always @* begin
    if (stack_select) begin
      stacked_out_d = wiper_one_terminal;
    end else begin
      stacked_out_d = wiper_zero_terminal;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      stacked_out <= `DWSP_MIDSCALE;
    end else begin
      stacked_out <= stacked_out_d;
    end
  end

  // taken straight from the last stage, with no gating by select
  assign cascade_out = shift_q[`DWSP_CASCADE_POS];
endmodule // dwsp_top
`default_nettype wire

// ---- testbench/dwsp_sva.sv ----
// checker for the serial port
`timescale 1ns/1ps
`default_nettype none
module dwsp_sva(input wire logic sys_clk,sys_rst,port_select,serial_clk,serial_data,cascade_out,stack_select,
  input wire logic [7:0] wiper_zero_terminal,wiper_one_terminal,stacked_out);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire [16:0] lat={wiper_zero_terminal,wiper_one_terminal,stack_select};
  mux_zero_a: assert property(!stack_select|=>stacked_out==$past(wiper_zero_terminal)) else $error("mux0");
  mux_one_a: assert property(stack_select|=>stacked_out==$past(wiper_one_terminal)) else $error("mux1");
  latch_hold_a: assert property(port_select[*6]|->$stable(lat)) else $error("hold");
  latch_when_a: assert property($changed(lat)|->!$past(port_select,2)) else $error("when");
  shift_sel_a: assert property($changed(cascade_out)|->$past(port_select,3)) else $error("shift");
  idle_port_a: assert property(!port_select[*6]|=>$stable(cascade_out)) else $error("idle");
  sel_rise_a: assert property($rose(port_select)&&!serial_clk|=>$stable(cascade_out)[*3]) else $error("rise");
  reset_val_a: assert property(disable iff(1'b0) sys_rst|=>lat==17'h10100&&!cascade_out) else $error("rst");
  cover property($fell(port_select));
  cover property(stack_select);
  cover property($changed(cascade_out));
endmodule // dwsp_sva
bind dwsp_top dwsp_sva chk(.*);
`default_nettype wire

// ---- testbench/dwsp_host.sv ----
// controller model driving the three-wire port
`timescale 1ns/1ps
`default_nettype none
module dwsp_host(input wire logic clk,cascade_out,output logic sel,sck,output wire logic sd);
  logic d_q=0,lb_q=0;
  assign sd=lb_q?cascade_out:d_q;
  initial begin sel=0; sck=0; end
  // first bit sent is w[16]; n is 17 or zero
  task automatic send(input [16:0] w,input int n,input logic s,lb);
    @(posedge clk); lb_q<=lb; sel<=s;
    for(int i=16;i>16-n;i--) begin
      repeat(5) @(posedge clk); d_q<=w[i]; sck<=0;
      repeat(5) @(posedge clk); sck<=1;
    end
    repeat(5) @(posedge clk); sck<=0;
    // released line shows the inverse so a stale value cannot pass
    repeat(5) @(posedge clk); sel<=0; lb_q<=0; d_q<=~d_q;
    repeat(8) @(posedge clk);
  endtask
endmodule // dwsp_host
`default_nettype wire

// ---- testbench/dwsp_top_bench.sv ----
// bench for the dual wiper serial port
`timescale 1ns/1ps
`default_nettype none
module dwsp_top_bench;
  logic sys_clk=0,sys_rst=1; wire ps,sc,sd,co,ss; wire [7:0] w0,w1,so; int bad_count=0,samples_checked=0,cyc=0;
  always #2.5 sys_clk=~sys_clk;
  dwsp_top dut(.sys_clk(sys_clk),.sys_rst(sys_rst),.port_select(ps),.serial_clk(sc),.serial_data(sd),
    .cascade_out(co),.wiper_zero_terminal(w0),.wiper_one_terminal(w1),.stack_select(ss),.stacked_out(so));
  dwsp_host host(.clk(sys_clk),.cascade_out(co),.sel(ps),.sck(sc),.sd(sd));
  task automatic cmp(input string n,input [7:0] e,g);
    samples_checked++;
    if(g!==e) begin bad_count++; $display("MISMATCH %s exp %h got %h",n,e,g); end
  endtask
  task automatic exp(input logic s,input [7:0] a,b,input logic c);
    cmp("stk",{7'h00,s},{7'h00,ss}); cmp("w1",a,w1); cmp("w0",b,w0);
    cmp("sout",s?a:b,so); cmp("cas",{7'h00,c},{7'h00,co});
  endtask
  task t_write(input logic s,input [7:0] a,b); host.send({s,a,b},17,1,0); exp(s,a,b,s); endtask
  task t_ignore; host.send(17'h1FFFF,17,0,0); host.send(0,0,1,0); exp(0,8'h3C,8'hC3,0); endtask
  task t_loop; host.send(0,17,1,1); exp(0,8'h3C,8'hC3,0); endtask
  task complete_run;
    if(bad_count==0&&samples_checked>0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) if(++cyc==5000) begin bad_count++; complete_run; end
  initial begin
    repeat(6) @(posedge sys_clk); sys_rst<=0; repeat(2) @(posedge sys_clk);
    exp(0,8'h80,8'h80,0);
    t_write(1,8'hA5,8'h5A); t_write(0,8'h3C,8'hC3); t_ignore; t_loop; complete_run;
  end
endmodule // dwsp_top_bench
`default_nettype wire
